// ==== rtl/tssc_core.v ====
// Thermometer status, configuration, rate timer and bus slave.
// Assumes bus pins and straps are asynchronous; ADC temps are on i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "tssc_consts.vh"
// Contract
// - Status read clears flags; persisting alarms reset
// - Flag clear leaves interrupt latch alone
// - Status: busy, four alarms, open, zeros
// - Alarm and open flags sticky until read
// - Mask bit suppresses interrupt output
// - Stop bit halts conversion, enters standby
// - Alarms refreshed at first SCL rise after stop
// - Open flag updated only at conversion start
// - Interrupt latch separate from status register
// - Rate codes 0-7 double from slowest
// - Rate register resets to code 02h
// - Only low three rate bits decoded
// - Results valid one conversion time after start
// - Rate change effective within new interval
// - One-shot ignored while converting
// - Address decoded from two three-state straps
// - Straps sampled only after reset
// - Also answer Alert Response Address
// - Power-up defaults: latch, rate, index, limits
// - Hardware standby at reset: temps read zero
// - One-shot between conversions restarts rate timer
// - Index 0Ah writes rate, 09h configuration
module tssc_core #(
  parameter [31:0] P_CONV_CYC = `TSSC_CONV_MS * `TSSC_CLK_KHZ,
  parameter [31:0] P_SLOW_CYC = `TSSC_SLOW_MS * `TSSC_CLK_KHZ
) (
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  output reg        o_alert_out,
  output reg        o_alert_oe,
  input  wire [1:0] i_addr_strap_a,
  input  wire [1:0] i_addr_strap_b,
  input  wire       i_hw_standby_pin_n,
  input  wire       i_diode_open,
  input  wire [7:0] i_local_temp,
  input  wire [7:0] i_remote_temp,
  output reg        o_conv_start,
  output reg        o_conv_busy
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_CMD  = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_READ = 3'h4;

  reg  [2:0]  scl_s;
  reg  [2:0]  sda_s;
  reg  [1:0]  hw_standby_pin_s;
  reg  [1:0]  open_s;
  reg  [1:0]  sa_s1, sa_s2, sb_s1, sb_s2;
  reg  [1:0]  init_cnt_reg;
  reg         strap_done_reg;
  reg  [6:0]  addr_reg;
  reg  [2:0]  st_reg;
  reg  [3:0]  bit_reg;
  reg         ack_ph_reg;
  reg         ack_reg;
  reg         ara_reg;
  reg         rd_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  tx_reg;
  reg         more_reg;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  cfg_reg;
  reg  [7:0]  rate_reg;
  reg  [7:0]  lhi_reg, llo_reg, rhi_reg, rlo_reg;
  reg  [7:0]  ltemp_reg, rtemp_reg;
  reg  [4:0]  flag_reg;
  reg  [4:0]  flag_next;
  reg         latch_reg;
  reg         stat_pend_reg;
  reg         refr_pend_reg;
  reg         ara_clr_reg;
  reg         shot_reg;
  reg         busy_reg;
  reg  [31:0] conv_cnt_reg;
  reg  [31:0] rate_cnt_reg;
  reg         hw_standby_pin_d_reg;
  reg         first_reg;
  reg  [6:0]  dec_addr;
  reg  [7:0]  rd_data;

  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c  = scl_s[1] & ~sda_s[1] & sda_s[2];
  wire stop_c   = scl_s[1] & sda_s[1] & ~sda_s[2];
  wire sda_in   = sda_s[1];
  wire hw_hw_standby_pin  = ~hw_standby_pin_s[1];
  wire standby  = cfg_reg[`TSSC_CFG_STOP] | hw_hw_standby_pin;
  wire hw_standby_pin_rise = standby & ~hw_standby_pin_d_reg;
  wire hw_standby_pin_fall = ~standby & hw_standby_pin_d_reg;
  wire [31:0] interval = P_SLOW_CYC >> rate_reg[2:0];
  wire rate_hit = (rate_cnt_reg >= interval - 32'h1);
  wire conv_go  = ~busy_reg & strap_done_reg &
                  ((first_reg & ~standby) | (shot_reg & ~hw_hw_standby_pin) |
                   hw_standby_pin_fall | (~standby & rate_hit));
  wire conv_done = busy_reg & ~hw_standby_pin_rise &
                   (conv_cnt_reg == P_CONV_CYC - 32'h1);
  wire [3:0] alarm_new = {$signed(i_local_temp) > $signed(lhi_reg),
                          $signed(i_local_temp) < $signed(llo_reg),
                          $signed(i_remote_temp) > $signed(rhi_reg),
                          $signed(i_remote_temp) < $signed(rlo_reg)};
  wire [3:0] alarm_now = {$signed(ltemp_reg) > $signed(lhi_reg),
                          $signed(ltemp_reg) < $signed(llo_reg),
                          $signed(rtemp_reg) > $signed(rhi_reg),
                          $signed(rtemp_reg) < $signed(rlo_reg)};
  wire clr_evt  = stop_c & stat_pend_reg;
  wire refr_evt = scl_rise & refr_pend_reg;
  wire flag_set = |(flag_next & ~flag_reg) & ~cfg_reg[`TSSC_CFG_MASK];
  wire latch_next = flag_set | (latch_reg & ~ara_clr_reg);
  wire [3:0] strap_idx = {sa_s2, sb_s2};

  // Strap decode
  always @* begin
    case (strap_idx)
      {`TSSC_STRAP_GND, `TSSC_STRAP_GND}:   dec_addr = `TSSC_ADDR_GG;
      {`TSSC_STRAP_GND, `TSSC_STRAP_OPEN}:  dec_addr = `TSSC_ADDR_GZ;
      {`TSSC_STRAP_OPEN, `TSSC_STRAP_GND}:  dec_addr = `TSSC_ADDR_ZG;
      {`TSSC_STRAP_OPEN, `TSSC_STRAP_OPEN}: dec_addr = `TSSC_ADDR_ZZ;
      default: begin
        if (sa_s2 == `TSSC_STRAP_GND)
          dec_addr = `TSSC_ADDR_GV;
        else if (sa_s2 == `TSSC_STRAP_OPEN)
          dec_addr = `TSSC_ADDR_ZV;
        else if (sb_s2 == `TSSC_STRAP_GND)
          dec_addr = `TSSC_ADDR_VG;
        else if (sb_s2 == `TSSC_STRAP_OPEN)
          dec_addr = `TSSC_ADDR_VZ;
        else
          dec_addr = `TSSC_ADDR_VV;
      end
    endcase
  end

  // Read data mux
  always @* begin
    if (ara_reg)
      rd_data = {addr_reg, 1'b0};
    else begin
      case (cmd_reg)
        `TSSC_CMD_LTEMP:   rd_data = ltemp_reg;
        `TSSC_CMD_RTEMP:   rd_data = rtemp_reg;
        `TSSC_CMD_STAT:    rd_data = {busy_reg, flag_reg, 2'h0};
        `TSSC_CMD_CFG_RD:  rd_data = {cfg_reg[7:6], 6'h00};
        `TSSC_CMD_RATE_RD: rd_data = rate_reg;
        `TSSC_CMD_LHI_RD:  rd_data = lhi_reg;
        `TSSC_CMD_LLO_RD:  rd_data = llo_reg;
        `TSSC_CMD_RHI_RD:  rd_data = rhi_reg;
        `TSSC_CMD_RLO_RD:  rd_data = rlo_reg;
        default:           rd_data = 8'hFF;
      endcase
    end
  end

  // Status flags: clear, refresh, then sets win
  always @* begin
    flag_next = flag_reg;
    if (clr_evt)
      flag_next = 5'h00;
    if (refr_evt)
      flag_next[4:1] = flag_next[4:1] | alarm_now;
    if (conv_done)
      flag_next[4:1] = flag_next[4:1] | alarm_new;
    if (conv_go & open_s[1])
      flag_next[0] = 1'b1;
  end

  // Synchronisers and strap capture
  always @(posedge i_clk_sys) begin
    scl_s  <= {scl_s[1:0], i_scl};
    sda_s  <= {sda_s[1:0], i_sda};
    hw_standby_pin_s <= {hw_standby_pin_s[0], i_hw_standby_pin_n};
    open_s <= {open_s[0], i_diode_open};
    sa_s1  <= i_addr_strap_a;
    sa_s2  <= sa_s1;
    sb_s1  <= i_addr_strap_b;
    sb_s2  <= sb_s1;
    if (!i_rst_n) begin
      init_cnt_reg   <= 2'h0;
      strap_done_reg <= 1'b0;
      addr_reg       <= `TSSC_ADDR_GG;
    end else if (!strap_done_reg) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
      if (init_cnt_reg == `TSSC_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        addr_reg       <= dec_addr;
      end
    end
  end

  // Bus slave
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= S_IDLE;
      bit_reg <= 4'h0;
      ack_ph_reg <= 1'b0;
      ack_reg <= 1'b0;
      ara_reg <= 1'b0;
      rd_reg <= 1'b0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      more_reg <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      cmd_reg <= `TSSC_CMD_LTEMP;
      cfg_reg <= `TSSC_CFG_RST;
      rate_reg <= `TSSC_RATE_RST;
      lhi_reg <= `TSSC_HI_RST;
      rhi_reg <= `TSSC_HI_RST;
      llo_reg <= `TSSC_LO_RST;
      rlo_reg <= `TSSC_LO_RST;
      shot_reg <= 1'b0;
      stat_pend_reg <= 1'b0;
      ara_clr_reg <= 1'b0;
    end else begin
      shot_reg <= 1'b0;
      ara_clr_reg <= 1'b0;
      if (clr_evt)
        stat_pend_reg <= 1'b0;
      if (start_c) begin
        st_reg <= S_ADDR;
        bit_reg <= 4'h0;
        ack_ph_reg <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_reg <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (st_reg == S_READ) begin
        if (scl_rise && bit_reg == `TSSC_BIT_LAST) begin
          more_reg <= ~sda_in;
          bit_reg <= bit_reg + 4'h1;
          if (!ara_reg && cmd_reg == `TSSC_CMD_STAT)
            stat_pend_reg <= 1'b1;
          if (ara_reg)
            ara_clr_reg <= 1'b1;
        end else if (scl_rise && bit_reg < `TSSC_BIT_LAST) begin
          bit_reg <= bit_reg + 4'h1;
        end else if (scl_fall && bit_reg > `TSSC_BIT_LAST) begin
          if (more_reg) begin
            tx_reg <= rd_data;
            o_sda_oe <= ~rd_data[7];
            bit_reg <= 4'h0;
          end else
            st_reg <= S_IDLE;
        end else if (scl_fall && bit_reg == `TSSC_BIT_LAST) begin
          o_sda_oe <= 1'b0;
        end else if (scl_fall && bit_reg != 4'h0) begin
          tx_reg <= {tx_reg[6:0], 1'b1};
          o_sda_oe <= ~tx_reg[6];
        end
      end else if (st_reg != S_IDLE) begin
        if (scl_rise && bit_reg < `TSSC_BIT_LAST) begin
          sh_reg <= {sh_reg[6:0], sda_in};
          bit_reg <= bit_reg + 4'h1;
        end else if (scl_fall && bit_reg == `TSSC_BIT_LAST && !ack_ph_reg) begin
          ack_ph_reg <= 1'b1;
          ack_reg <= 1'b1;
          if (st_reg == S_ADDR) begin
            rd_reg <= sh_reg[0];
            ara_reg <= (sh_reg[7:1] == `TSSC_ARA);
            if (sh_reg[7:1] == `TSSC_ARA)
              ack_reg <= latch_reg & sh_reg[0];
            else if (sh_reg[7:1] != addr_reg)
              ack_reg <= 1'b0;
            o_sda_oe <= (sh_reg[7:1] == addr_reg) |
                        ((sh_reg[7:1] == `TSSC_ARA) & latch_reg & sh_reg[0]);
          end else begin
            o_sda_oe <= 1'b1;
            if (st_reg == S_CMD) begin
              cmd_reg <= sh_reg;
              if (sh_reg == `TSSC_CMD_ONESHOT)
                shot_reg <= 1'b1;
            end else begin
              case (cmd_reg)
                `TSSC_CMD_CFG_WR:  cfg_reg <= {sh_reg[7:6], 6'h00};
                `TSSC_CMD_RATE_WR: rate_reg <= sh_reg;
                `TSSC_CMD_LHI_WR:  lhi_reg <= sh_reg;
                `TSSC_CMD_LLO_WR:  llo_reg <= sh_reg;
                `TSSC_CMD_RHI_WR:  rhi_reg <= sh_reg;
                `TSSC_CMD_RLO_WR:  rlo_reg <= sh_reg;
                default: cfg_reg <= cfg_reg;
              endcase
            end
          end
        end else if (scl_fall && ack_ph_reg) begin
          ack_ph_reg <= 1'b0;
          bit_reg <= 4'h0;
          o_sda_oe <= 1'b0;
          if (!ack_reg)
            st_reg <= S_IDLE;
          else if (st_reg == S_ADDR && rd_reg) begin
            st_reg <= S_READ;
            tx_reg <= rd_data;
            o_sda_oe <= ~rd_data[7];
          end else if (st_reg == S_ADDR)
            st_reg <= S_CMD;
          else
            st_reg <= S_DATA;
        end
      end
    end
  end

  // Conversion control, flags and interrupt latch
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      conv_cnt_reg <= 32'h0;
      rate_cnt_reg <= 32'h0;
      hw_standby_pin_d_reg <= 1'b0;
      first_reg <= 1'b1;
      ltemp_reg <= `TSSC_TEMP_RST;
      rtemp_reg <= `TSSC_TEMP_RST;
      flag_reg <= 5'h00;
      latch_reg <= 1'b0;
      refr_pend_reg <= 1'b0;
      o_alert_oe <= 1'b0;
      o_alert_out <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_busy <= 1'b0;
    end else begin
      hw_standby_pin_d_reg <= standby;
      o_conv_start <= conv_go;
      flag_reg <= flag_next;
      latch_reg <= latch_next;
      o_alert_oe <= latch_next & ~cfg_reg[`TSSC_CFG_MASK];
      if (clr_evt)
        refr_pend_reg <= 1'b1;
      else if (scl_rise)
        refr_pend_reg <= 1'b0;
      if (conv_go)
        first_reg <= 1'b0;
      if (hw_standby_pin_rise) begin
        busy_reg <= 1'b0;
        o_conv_busy <= 1'b0;
      end else if (conv_go) begin
        busy_reg <= 1'b1;
        o_conv_busy <= 1'b1;
        conv_cnt_reg <= 32'h0;
      end else if (conv_done) begin
        busy_reg <= 1'b0;
        o_conv_busy <= 1'b0;
        ltemp_reg <= i_local_temp;
        rtemp_reg <= i_remote_temp;
      end else if (busy_reg)
        conv_cnt_reg <= conv_cnt_reg + 32'h1;
      if (conv_go || standby)
        rate_cnt_reg <= 32'h0;
      else if (!rate_hit)
        rate_cnt_reg <= rate_cnt_reg + 32'h1;
    end
  end
endmodule // tssc_core
`default_nettype wire

// ==== shared/tssc_consts.vh ====
// Constants for the thermometer status and control block.
// Assumes a 25 MHz system clock.
`ifndef TSSC_CONSTS_VH
`define TSSC_CONSTS_VH
`define TSSC_CLK_KHZ      25000
`define TSSC_CONV_MS      125
`define TSSC_SLOW_MS      16000
`define TSSC_CMD_LTEMP    8'h00
`define TSSC_CMD_RTEMP    8'h01
`define TSSC_CMD_STAT     8'h02
`define TSSC_CMD_CFG_RD   8'h03
`define TSSC_CMD_RATE_RD  8'h04
`define TSSC_CMD_LHI_RD   8'h05
`define TSSC_CMD_LLO_RD   8'h06
`define TSSC_CMD_RHI_RD   8'h07
`define TSSC_CMD_RLO_RD   8'h08
`define TSSC_CMD_CFG_WR   8'h09
`define TSSC_CMD_RATE_WR  8'h0A
`define TSSC_CMD_LHI_WR   8'h0B
`define TSSC_CMD_LLO_WR   8'h0C
`define TSSC_CMD_RHI_WR   8'h0D
`define TSSC_CMD_RLO_WR   8'h0E
`define TSSC_CMD_ONESHOT  8'h0F
`define TSSC_CFG_MASK     7
`define TSSC_CFG_STOP     6
`define TSSC_CFG_RST      8'h00
`define TSSC_RATE_RST     8'h02
`define TSSC_HI_RST       8'h7F
`define TSSC_LO_RST       8'hC9
`define TSSC_TEMP_RST     8'h00
`define TSSC_ARA          7'h0C
`define TSSC_STRAP_GND    2'h0
`define TSSC_STRAP_OPEN   2'h1
`define TSSC_ADDR_GG      7'h18
`define TSSC_ADDR_GZ      7'h19
`define TSSC_ADDR_GV      7'h1A
`define TSSC_ADDR_ZG      7'h29
`define TSSC_ADDR_ZZ      7'h2A
`define TSSC_ADDR_ZV      7'h2B
`define TSSC_ADDR_VG      7'h4C
`define TSSC_ADDR_VZ      7'h4D
`define TSSC_ADDR_VV      7'h4E
`define TSSC_STRAP_WAIT   2'h3
`define TSSC_BIT_LAST     4'h8
`endif

// ==== bench/tssc_monitor.sv ====
// Port checker for the thermometer core, bound to every instance.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tssc_monitor #(
  parameter [31:0] P_CONV_CYC = 32'h002FAF08,
  parameter [31:0] P_SLOW_CYC = 32'h17D78400
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic       o_alert_out,
  input wire logic       o_alert_oe,
  input wire logic [1:0] i_addr_strap_a,
  input wire logic [1:0] i_addr_strap_b,
  input wire logic       i_hw_standby_pin_n,
  input wire logic       i_diode_open,
  input wire logic [7:0] i_local_temp,
  input wire logic [7:0] i_remote_temp,
  input wire logic       o_conv_start,
  input wire logic       o_conv_busy
);
  logic [31:0] busy_cnt_reg;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Length of the current busy run
  always @(posedge i_clk_sys) begin
    if (!i_rst_n || !o_conv_busy) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_sda_oe && !o_alert_oe && !o_conv_busy)
    else $error("outputs active after reset");
  a_boot_convert: assert property ($rose(i_rst_n) && i_hw_standby_pin_n |-> ##[1:12] o_conv_start)
    else $error("no conversion after reset");
  a_start_busy: assert property (o_conv_start |=> o_conv_busy)
    else $error("start without busy");
  a_no_restart: assert property (o_conv_busy && $past(o_conv_busy) |-> !o_conv_start)
    else $error("start during conversion");
  a_busy_bound: assert property (busy_cnt_reg <= P_CONV_CYC)
    else $error("conversion too long");
  a_hw_standby: assert property ((!i_hw_standby_pin_n)[*6] |-> !o_conv_busy && !o_conv_start)
    else $error("converting in standby");
  a_sda_change: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("data moved with clock high");
  a_sda_od: assert property (!o_sda_out)
    else $error("data line driven high");
  a_alert_od: assert property (!o_alert_out)
    else $error("alert line driven high");
  c_start: cover property (o_conv_start);
  c_alert: cover property ($rose(o_alert_oe));
  c_ack: cover property ($rose(o_sda_oe));
endmodule // tssc_monitor
bind tssc_core tssc_monitor #(.P_CONV_CYC(P_CONV_CYC), .P_SLOW_CYC(P_SLOW_CYC)) u_mon (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_alert_out(o_alert_out),
  .o_alert_oe(o_alert_oe), .i_addr_strap_a(i_addr_strap_a), .i_addr_strap_b(i_addr_strap_b),
  .i_hw_standby_pin_n(i_hw_standby_pin_n), .i_diode_open(i_diode_open),
  .i_local_temp(i_local_temp), .i_remote_temp(i_remote_temp),
  .o_conv_start(o_conv_start), .o_conv_busy(o_conv_busy));
`default_nettype wire

// ==== bench/tssc_host.sv ====
// Bus host model: makes the 320 ns bus clock and pulls the data line.
// Assumes a pull-up on the data line; the clock idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module tssc_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // One bit; data moves mid low phase, sampled mid high phase
  task automatic bt(input logic b, output logic r);
    tick(2);
    o_sda_low = ~b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl = 1'b0;
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ack = ~r;
  endtask
  task automatic edge_cond(input logic stop);
    if (stop) begin
      tick(2);
      o_sda_low = 1'b1;
      tick(2);
      o_scl = 1'b1;
      tick(2);
      o_sda_low = 1'b0;
      tick(4);
    end else begin
      o_sda_low = 1'b1;
      tick(2);
      o_scl = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input int nb, output logic ok);
    logic k;
    edge_cond(1'b0);
    byte_w({a, 1'b0}, ok);
    if (ok && nb > 0) byte_w(c, k);
    if (ok && nb > 1) byte_w(d, k);
    edge_cond(1'b1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic ok);
    logic r;
    edge_cond(1'b0);
    byte_w({a, 1'b1}, ok);
    q = 8'hFF;
    if (ok) begin
      for (int i = 7; i >= 0; i--) bt(1'b1, q[i]);
      bt(1'b1, r);
    end
    edge_cond(1'b1);
  endtask
endmodule // tssc_host
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the thermometer status and control core.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CONV = 200;
  localparam int SLOW = 4000;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] strap_a = 2'h2;
  logic [1:0] strap_b = 2'h0;
  logic       hw_standby_pin_n = 1'b1;
  logic       diode_open = 1'b0;
  logic [7:0] ltemp = 8'h00;
  logic [7:0] rtemp = 8'h00;
  logic [6:0] addr = 7'h4C;
  wire        scl, host_low, sda_out, sda_oe, alert_out, alert_oe, conv_start, conv_busy;
  wire        sda = ~(host_low | sda_oe);
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         n_starts = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (conv_start === 1'b1) n_starts <= n_starts + 1;
  tssc_core #(.P_CONV_CYC(CONV), .P_SLOW_CYC(SLOW)) DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_alert_out(alert_out), .o_alert_oe(alert_oe),
    .i_addr_strap_a(strap_a), .i_addr_strap_b(strap_b), .i_hw_standby_pin_n(hw_standby_pin_n),
    .i_diode_open(diode_open), .i_local_temp(ltemp), .i_remote_temp(rtemp),
    .o_conv_start(conv_start), .o_conv_busy(conv_busy));
  tssc_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reset_dut;
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(12);
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
    logic ok;
    host.wr(addr, c, d, 2, ok);
    check("write ack", ok, 1'b1);
  endtask
  task automatic oneshot;
    logic ok;
    host.wr(addr, 8'h0F, 8'h00, 1, ok);
  endtask
  task automatic exp_reg(input logic [7:0] c, input logic [7:0] e);
    logic       ok;
    logic [7:0] q;
    host.wr(addr, c, 8'h00, 1, ok);
    host.rd(addr, q, ok);
    if (c == 8'h02 && q[6:0] == 7'h7F) host.rd(addr, q, ok);
    check($sformatf("reg %h", c), q, e);
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (conv_start !== 1'b1 && n < 9000);
  endtask
  task automatic gap_chk(input int e);
    int n;
    int lo;
    lo = e > CONV ? e : CONV;
    wait_start(n);
    wait_start(n);
    check("gap", n >= lo && n <= lo + 6, 1'b1);
  endtask
  task automatic t_defaults;
    logic [7:0] q;
    logic       ok;
    host.rd(addr, q, ok);
    check("index zero", q, 8'h00);
    exp_reg(8'h03, 8'h00);
    exp_reg(8'h04, 8'h02);
    for (int i = 5; i <= 8; i++) exp_reg(i[7:0], i[0] ? 8'h7F : 8'hC9);
    host.wr(7'h18, 8'h00, 8'h00, 0, ok);
    check("foreign addr", ok, 1'b0);
    gap_chk(SLOW >> 2);
  endtask
  task automatic t_rate;
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h0A, 8'hF8 | c[7:0]);
      gap_chk(SLOW >> c);
    end
    exp_reg(8'h04, 8'hFF);
  endtask
  task automatic t_oneshot;
    int n;
    int k;
    wr_reg(8'h0A, 8'h00);
    wait_start(n);
    cyc(2);
    k = n_starts;
    oneshot;
    check("busy oneshot", n_starts - k, 0);
    wait_start(n);
    check("no restart", n >= SLOW - 400 && n <= SLOW, 1'b1);
    cyc(1000);
    k = n_starts;
    oneshot;
    cyc(8);
    check("oneshot start", n_starts - k, 1);
    wait_start(n);
    check("timer restart", n >= SLOW - 200 && n <= SLOW + 6, 1'b1);
  endtask
  task automatic t_status;
    logic [7:0] q;
    logic       ok;
    int         k;
    wr_reg(8'h0A, 8'h07);
    wr_reg(8'h09, 8'h40);
    cyc(CONV);
    k = n_starts;
    cyc(600);
    check("stopped", n_starts - k, 0);
    ltemp = 8'h80;
    diode_open = 1'b1;
    oneshot;
    cyc(CONV + 20);
    exp_reg(8'h02, 8'h24);
    check("alert set", alert_oe, 1'b1);
    ltemp = 8'h00;
    diode_open = 1'b0;
    oneshot;
    cyc(CONV + 20);
    exp_reg(8'h02, 8'h20);
    exp_reg(8'h02, 8'h00);
    check("alert kept", alert_oe, 1'b1);
    wr_reg(8'h09, 8'hC0);
    check("alert masked", alert_oe, 1'b0);
    exp_reg(8'h03, 8'hC0);
    wr_reg(8'h09, 8'h00);
    check("alert back", alert_oe, 1'b1);
    host.rd(7'h0C, q, ok);
    check("ara ack", ok, 1'b1);
    check("alert clear", alert_oe, 1'b0);
    host.rd(7'h0C, q, ok);
    check("ara idle", ok, 1'b0);
  endtask
  task automatic t_strap;
    logic ok;
    strap_a = 2'h0;
    strap_b = 2'h1;
    host.wr(7'h19, 8'h00, 8'h00, 0, ok);
    check("late strap", ok, 1'b0);
    hw_standby_pin_n = 1'b0;
    ltemp = 8'h55;
    rtemp = 8'h66;
    reset_dut;
    addr = 7'h19;
    exp_reg(8'h00, 8'h00);
    exp_reg(8'h01, 8'h00);
    hw_standby_pin_n = 1'b1;
    cyc(CONV + 20);
    exp_reg(8'h00, 8'h55);
    exp_reg(8'h01, 8'h66);
  endtask
  initial begin
    reset_dut;
    t_defaults;
    t_rate;
    t_oneshot;
    t_status;
    t_strap;
    final_report;
  end
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule // testbench
`default_nettype wire
